// ===== pkg/gtp_map.vh
// Purpose: Constants of the gauge I2C target port.
// Assumes: 40 MHz system clock; SCL and SDA sampled as synchronous inputs.
// Notes: Included by every gtp design file.
// Contract
// - Address byte 0xAA writes, 0xAB reads.
// - Support write, quick, single and incremental reads.
// - Quick read returns byte at current pointer.
// - Pointer advances on every acknowledged data byte until it reaches 0x80.
// - Written data bytes go to consecutive locations.
// - NACK and drop data to read-only location.
// - NACK command byte above 0x7F.
// - NACK data bytes beyond command's permitted count.
// - Stuck-low bus timeout releases SDA and SCL.
// - Line still low after release: request sleep.
// - Sealed: NACK command bytes 0x3e and 0x3f.
`ifndef GTP_MAP_VH
`define GTP_MAP_VH

`define GTP_DEV_ADDR 7'h55
`define GTP_ADDR_WR 8'haa
`define GTP_ADDR_RD 8'hab
`define GTP_CMD_MAX 8'h7f
`define GTP_CMD_CLASS 8'h3e
`define GTP_CMD_BLOCK 8'h3f
`define GTP_CMD_CNTL 8'h00
`define GTP_CMD_ATRATE 8'h10
`define GTP_CMD_BLK_LO 8'h40
`define GTP_CMD_AUTH_HI 8'h54
`define GTP_CMD_BLK_HI 8'h5f
`define GTP_CMD_BLK_CKS 8'h60
`define GTP_CMD_BLK_CTL 8'h61
`define GTP_PTR_RST 8'h00
`define GTP_PAST_TOP 8'hff
`define GTP_CLK_HZ 40000000
`define GTP_STUCK_US 2000
`define GTP_STUCK_CYC 24'd80000 // GTP_STUCK_US at GTP_CLK_HZ, sized for the counter
`define GTP_SETTLE_CYC 24'd16

`endif

// ===== hw/gtp_stuck_bus.v
// Purpose: Stuck-bus watchdog for the gauge I2C target port.
// Assumes: scl_in and sda_in synchronous to clock.
// Notes: Release is a one-cycle pulse; sleep is a level until the bus idles high.
`timescale 1ns/1ps
`include "gtp_map.vh"
module gtp_stuck_bus #(
    parameter [23:0] TIMEOUT_CYC = `GTP_STUCK_CYC,
    parameter [23:0] SETTLE_CYC = `GTP_SETTLE_CYC
) (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire scl_in,
    input wire sda_in,
    output reg release_r,
    output reg sleep_r
);
    localparam [23:0] SLEEP_AT = TIMEOUT_CYC + SETTLE_CYC;
    reg [23:0] cnt_r;

    // Count low time of either line, saturating past the settle window
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= 24'h0;
            release_r <= 1'b0;
            sleep_r <= 1'b0;
        end else if (ce) begin
            if (scl_in && sda_in) begin
                cnt_r <= 24'h0;
                release_r <= 1'b0;
                sleep_r <= 1'b0;
            end else begin
                if (cnt_r != SLEEP_AT) begin
                    cnt_r <= cnt_r + 24'h1;
                end
                release_r <= (cnt_r == TIMEOUT_CYC - 24'h1);
                if (cnt_r == SLEEP_AT - 24'h1) begin
                    sleep_r <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== hw/gtp_i2c_target.v
// Purpose: I2C target engine reaching the gauge's byte-wide command space.
// Assumes: Command space answers rd_data combinationally for cmd_ptr.
// Notes: No clock stretching; scl_oe stays low, SCL is only ever observed.
`timescale 1ns/1ps
`include "gtp_map.vh"
module gtp_i2c_target #(
    parameter [23:0] TIMEOUT_CYC = `GTP_STUCK_CYC,
    parameter [23:0] SETTLE_CYC = `GTP_SETTLE_CYC
) (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire scl_in,
    output reg scl_out,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire sealed,
    input wire [7:0] rd_data,
    output reg [7:0] cmd_ptr,
    output reg rd_stb,
    output reg wr_stb,
    output reg [7:0] wr_addr,
    output reg [7:0] wr_data,
    output reg sleep_req
);
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_RX = 5'b00010;
    localparam [4:0] ST_ACK = 5'b00100;
    localparam [4:0] ST_TX = 5'b01000;
    localparam [4:0] ST_RACK = 5'b10000;
    localparam [1:0] PH_ADDR = 2'h0;
    localparam [1:0] PH_CMD = 2'h1;
    localparam [1:0] PH_DATA = 2'h2;

    reg [4:0] state_r;
    reg [1:0] phase_r;
    reg [7:0] shift_r;
    reg [3:0] bitcnt_r;
    reg scl_q_r;
    reg sda_q_r;
    reg is_read_r;
    reg host_ack_r;
    reg [5:0] wr_cnt_r;
    reg [5:0] wr_lim_r;
    wire bus_release;
    wire bus_sleep;

    wire scl_rise = scl_in & ~scl_q_r;
    wire scl_fall = ~scl_in & scl_q_r;
    wire start_c = scl_in & scl_q_r & sda_q_r & ~sda_in;
    wire stop_c = scl_in & scl_q_r & ~sda_q_r & sda_in;
    wire past_top = (cmd_ptr > `GTP_CMD_MAX);
    wire [7:0] tx_byte = past_top ? `GTP_PAST_TOP : rd_data;

    // Writable locations of the command space, sealed state considered
    function wr_ok;
        input [7:0] a;
        input s;
        begin
            wr_ok = (a == `GTP_CMD_CNTL) || (a == `GTP_CMD_CNTL + 8'h1)
                || (a == `GTP_CMD_ATRATE) || (a == `GTP_CMD_ATRATE + 8'h1)
                || (a == `GTP_CMD_CLASS) || (a == `GTP_CMD_BLOCK)
                || ((a >= `GTP_CMD_BLK_LO) && (a <= `GTP_CMD_AUTH_HI))
                || (!s && (a > `GTP_CMD_AUTH_HI) && (a <= `GTP_CMD_BLK_HI))
                || (a == `GTP_CMD_BLK_CKS) || (!s && (a == `GTP_CMD_BLK_CTL));
        end
    endfunction

    // Data bytes one command byte may carry: word, block run or single
    function [5:0] wr_limit;
        input [7:0] a;
        reg [7:0] span;
        begin
            span = `GTP_CMD_BLK_CTL - a;
            if ((a >= `GTP_CMD_BLK_LO) && (a <= `GTP_CMD_BLK_CKS)) begin
                wr_limit = span[5:0]; // Run ends at the block checksum
            end else if (a < `GTP_CMD_CLASS) begin
                wr_limit = 6'h2;
            end else begin
                wr_limit = 6'h1;
            end
        end
    endfunction

    // Stuck-bus watchdog
    gtp_stuck_bus #(
        .TIMEOUT_CYC(TIMEOUT_CYC),
        .SETTLE_CYC(SETTLE_CYC)
    ) u_stuck (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .release_r(bus_release),
        .sleep_r(bus_sleep)
    );

    // Protocol engine
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            phase_r <= PH_ADDR;
            shift_r <= 8'h0;
            bitcnt_r <= 4'h0;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            is_read_r <= 1'b0;
            host_ack_r <= 1'b0;
            wr_cnt_r <= 6'h0;
            wr_lim_r <= 6'h0;
            cmd_ptr <= `GTP_PTR_RST;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            rd_stb <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h0;
            wr_data <= 8'h0;
            sleep_req <= 1'b0;
        end else if (ce) begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
            rd_stb <= 1'b0;
            wr_stb <= 1'b0;
            sleep_req <= bus_sleep;
            if (bus_release) begin
                state_r <= ST_IDLE;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
            end else if (start_c) begin
                state_r <= ST_RX;
                phase_r <= PH_ADDR;
                bitcnt_r <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state_r <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_in};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end else if (scl_fall && (bitcnt_r == 4'h8)) begin
                            state_r <= ST_ACK;
                            case (phase_r)
                                PH_ADDR: begin
                                    if (shift_r[7:1] == `GTP_DEV_ADDR) begin
                                        is_read_r <= shift_r[0];
                                        sda_oe <= 1'b1;
                                    end else begin
                                        state_r <= ST_IDLE;
                                    end
                                end
                                PH_CMD: begin
                                    if ((shift_r > `GTP_CMD_MAX)
                                        || (sealed && ((shift_r == `GTP_CMD_CLASS)
                                        || (shift_r == `GTP_CMD_BLOCK)))) begin
                                        state_r <= ST_IDLE;
                                    end else begin
                                        cmd_ptr <= shift_r;
                                        wr_cnt_r <= 6'h0;
                                        wr_lim_r <= wr_limit(shift_r);
                                        sda_oe <= 1'b1;
                                    end
                                end
                                default: begin
                                    // Refused bytes are left unacknowledged, bus kept
                                    if (wr_ok(cmd_ptr, sealed)
                                        && (wr_cnt_r < wr_lim_r)) begin
                                        sda_oe <= 1'b1;
                                        wr_stb <= 1'b1;
                                        wr_addr <= cmd_ptr;
                                        wr_data <= shift_r;
                                        cmd_ptr <= cmd_ptr + 8'h1;
                                        wr_cnt_r <= wr_cnt_r + 6'h1;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bitcnt_r <= 4'h0;
                            if ((phase_r == PH_ADDR) && is_read_r) begin
                                shift_r <= tx_byte;
                                rd_stb <= ~past_top;
                                sda_oe <= ~tx_byte[7];
                                state_r <= ST_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                phase_r <= (phase_r == PH_ADDR) ? PH_CMD : PH_DATA;
                                state_r <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bitcnt_r == 4'h7) begin
                                sda_oe <= 1'b0;
                                state_r <= ST_RACK;
                            end else begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sda_oe <= ~shift_r[6];
                                bitcnt_r <= bitcnt_r + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            host_ack_r <= ~sda_in;
                            if (!sda_in && !past_top) begin
                                cmd_ptr <= cmd_ptr + 8'h1;
                            end
                        end else if (scl_fall) begin
                            bitcnt_r <= 4'h0;
                            if (host_ack_r) begin
                                shift_r <= tx_byte;
                                rd_stb <= ~past_top;
                                sda_oe <= ~tx_byte[7];
                                state_r <= ST_TX;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// ===== test/gtp_props.sv
// Purpose: Port-level assertions for the gauge I2C target port.
// Assumes: Both lines pulled up; low-time counter frozen with ce like the design.
// Notes: Bound into gtp_i2c_target.
`timescale 1ns/1ps
module gtp_props #(
    parameter [23:0] TIMEOUT_CYC = 24'd80000,
    parameter [23:0] SETTLE_CYC = 24'd16
) (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire scl_in,
    input wire sda_in,
    input wire scl_oe,
    input wire sda_out,
    input wire sda_oe,
    input wire sealed,
    input wire [7:0] cmd_ptr,
    input wire rd_stb,
    input wire wr_stb,
    input wire [7:0] wr_addr,
    input wire sleep_req
);
    reg [23:0] low_cnt_r;
    wire [23:0] low_cnt_nxt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Cycles with either line low, saturating
    assign low_cnt_nxt = !ce ? low_cnt_r : (scl_in && sda_in) ? 24'h000000 :
        ((low_cnt_r == 24'hffffff) ? low_cnt_r : low_cnt_r + 24'h000001);
    always @(posedge clock or posedge rst) begin
        if (rst) low_cnt_r <= 24'h000000;
        else low_cnt_r <= low_cnt_nxt;
    end
    property p_no_drive_high; scl_oe == 1'b0 && sda_out == 1'b0; endproperty
    a_no_drive_high: assert property (p_no_drive_high) else $error("line driven");
    property p_wr_pulse; wr_stb |=> !wr_stb; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    property p_wr_ptr; wr_stb |-> cmd_ptr == wr_addr + 8'h01; endproperty
    a_wr_ptr: assert property (p_wr_ptr) else $error("pointer not advanced");
    property p_wr_ack; wr_stb |-> sda_oe; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("stored byte not acked");
    property p_wr_range; wr_stb |-> wr_addr <= 8'h7f; endproperty
    a_wr_range: assert property (p_wr_range) else $error("write above top");
    property p_sealed; sealed && wr_stb |-> wr_addr != 8'h3e && wr_addr != 8'h3f; endproperty
    a_sealed: assert property (p_sealed) else $error("sealed location written");
    property p_rd_top; rd_stb |-> cmd_ptr <= 8'h7f; endproperty
    a_rd_top: assert property (p_rd_top) else $error("read above top");
    property p_ptr_sat; cmd_ptr <= 8'h80; endproperty
    a_ptr_sat: assert property (p_ptr_sat) else $error("pointer past limit");
    property p_sleep; $rose(sleep_req) |-> low_cnt_r >= TIMEOUT_CYC; endproperty
    a_sleep: assert property (p_sleep) else $error("early sleep");
    property p_release; low_cnt_r > TIMEOUT_CYC + 24'd4 |-> !sda_oe; endproperty
    a_release: assert property (p_release) else $error("stuck bus not released");
endmodule
bind gtp_i2c_target gtp_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .SETTLE_CYC(SETTLE_CYC)) u_props (
    .clock(clock), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .sealed(sealed), .cmd_ptr(cmd_ptr),
    .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_addr(wr_addr), .sleep_req(sleep_req));

// ===== test/gtp_host_model.sv
// Purpose: I2C host controller model for the gauge target port.
// Assumes: Open-drain lines with pull-ups; each SCL phase lasts 4 clocks.
// Notes: Released lines float to the pull-up level.
`timescale 1ns/1ps
module gtp_host_model (
    input wire clock,
    input wire sda_oe,
    output reg scl_h,
    output reg sda_h
);
    wire sda_line = sda_h & ~sda_oe;
    // Bus idles with both lines released
    initial begin
        scl_h = 1'b1;
        sda_h = 1'b1;
    end
    task tick(input integer n);
        repeat (n) @(negedge clock);
    endtask
    task set_scl(input v);
        scl_h = v;
    endtask
    // One SCL period: SDA changes only while SCL is low
    task bit_x(input b, output s);
        begin
            tick(2);
            sda_h = b;
            tick(2);
            scl_h = 1'b1;
            tick(2);
            s = sda_line;
            tick(2);
            scl_h = 1'b0;
        end
    endtask
    // Start or repeated start
    task start;
        begin
            tick(2);
            sda_h = 1'b1;
            tick(2);
            scl_h = 1'b1;
            tick(4);
            sda_h = 1'b0;
            tick(4);
            scl_h = 1'b0;
        end
    endtask
    task stop;
        begin
            tick(2);
            sda_h = 1'b0;
            tick(2);
            scl_h = 1'b1;
            tick(4);
            sda_h = 1'b1;
            tick(4);
        end
    endtask
    // Byte out MSB first, returns the acknowledge level
    task wbyte(input [7:0] v, output nak);
        integer i;
        reg s;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_x(v[i], s);
            bit_x(1'b1, nak);
        end
    endtask
    // Byte in, then host acknowledge or not
    task rbyte(input nak, output [7:0] v);
        integer i;
        reg s;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_x(1'b1, v[i]);
            bit_x(nak, s);
        end
    endtask
endmodule

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the gauge I2C target port.
// Assumes: Command space modelled as pointer xor 0x5a.
// Notes: Stuck-bus timeout shortened to 200 clocks.
`timescale 1ns/1ps
module tb_top;
    reg clock, rst, sealed, a, ce;
    reg [7:0] v, got_addr, got_data;
    wire scl_h, sda_h, scl_out, scl_oe, sda_out, sda_oe, rd_stb, wr_stb, sleep_req;
    wire [7:0] cmd_ptr, wr_addr, wr_data;
    wire [7:0] rd_data = cmd_ptr ^ 8'h5a;
    integer mismatches, samples_checked;
    integer rd_cnt = 0;
    gtp_host_model host (.clock(clock), .sda_oe(sda_oe), .scl_h(scl_h), .sda_h(sda_h));
    gtp_i2c_target #(.TIMEOUT_CYC(24'd200)) dut (.clock(clock),
        .rst(rst), .ce(ce), .scl_in(scl_h), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_h & ~sda_oe), .sda_out(sda_out), .sda_oe(sda_oe), .sealed(sealed),
        .rd_data(rd_data), .cmd_ptr(cmd_ptr), .rd_stb(rd_stb), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data), .sleep_req(sleep_req));
    // Clock and captured writes
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) if (wr_stb === 1'b1) begin
        got_addr <= wr_addr;
        got_data <= wr_data;
    end
    // Count read strobes of the command space
    always @(posedge clock) if (rd_stb === 1'b1) rd_cnt <= rd_cnt + 1;
    task check(input string name, input [7:0] exp, input [7:0] seen);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task conclude;
        begin
            if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task sc_write;
        begin
            host.start;
            host.wbyte(8'haa, a);
            check("addr_ack", 8'h00, {7'h00, a});
            host.wbyte(8'h10, a);
            host.wbyte(8'h34, a);
            check("addr0", 8'h10, got_addr);
            host.wbyte(8'h56, a);
            check("data1", 8'h56, got_data);
            check("addr1", 8'h11, got_addr);
            host.wbyte(8'h78, a);
            check("extra_nak", 8'h01, {7'h00, a});
            check("ptr", 8'h12, cmd_ptr);
            host.stop;
        end
    endtask
    task sc_refuse;
        begin
            host.start;
            host.wbyte(8'ha8, a);
            check("foreign", 8'h01, {7'h00, a});
            host.stop;
            host.start;
            host.wbyte(8'haa, a);
            host.wbyte(8'h14, a);
            host.wbyte(8'h99, a);
            check("ro_nak", 8'h01, {7'h00, a});
            check("ro_keep", 8'h14, cmd_ptr);
            check("ro_nowr", 8'h11, got_addr);
            host.stop;
            host.start;
            host.wbyte(8'haa, a);
            host.wbyte(8'h80, a);
            check("cmd_top", 8'h01, {7'h00, a});
            host.stop;
            sealed = 1'b1;
            host.start;
            host.wbyte(8'haa, a);
            host.wbyte(8'h3e, a);
            check("sealed", 8'h01, {7'h00, a});
            host.stop;
            sealed = 1'b0;
        end
    endtask
    task sc_read;
        begin
            host.start;
            host.wbyte(8'haa, a);
            host.wbyte(8'h20, a);
            host.start;
            host.wbyte(8'hab, a);
            host.rbyte(1'b1, v);
            host.stop;
            check("one_rd", 8'h20 ^ 8'h5a, v);
            host.start;
            host.wbyte(8'hab, a);
            host.rbyte(1'b0, v);
            check("quick", 8'h20 ^ 8'h5a, v);
            host.rbyte(1'b1, v);
            check("incr", 8'h21 ^ 8'h5a, v);
            check("rd_stb", 8'h03, rd_cnt[7:0]);
            host.stop;
        end
    endtask
    task sc_top;
        begin
            host.start;
            host.wbyte(8'haa, a);
            host.wbyte(8'h7f, a);
            host.start;
            host.wbyte(8'hab, a);
            host.rbyte(1'b0, v);
            check("top", 8'h7f ^ 8'h5a, v);
            host.rbyte(1'b0, v);
            check("past", 8'hff, v);
            host.rbyte(1'b1, v);
            check("past2", 8'hff, v);
            check("sat", 8'h80, cmd_ptr);
            check("rd_top", 8'h04, rd_cnt[7:0]);
            host.stop;
        end
    endtask
    // Host stalls SCL low while the device drives the address ACK
    task sc_stuck;
        integer i;
        reg [7:0] adr;
        begin
            adr = 8'haa;
            host.start;
            for (i = 7; i >= 0; i = i - 1) host.bit_x(adr[i], a);
            host.tick(2);
            check("stuck_ack", 8'h01, {7'h00, sda_oe});
            host.tick(238);
            check("sleep", 8'h01, {7'h00, sleep_req});
            check("released", 8'h00, {7'h00, sda_oe});
            check("scl_drv", 8'h00, {5'h00, scl_out, scl_oe, sda_out});
            host.stop;
            check("wake", 8'h00, {7'h00, sleep_req});
        end
    endtask
    // Clock enable low freezes the stuck-bus watchdog
    task sc_freeze;
        begin
            ce = 1'b0;
            host.set_scl(1'b0);
            host.tick(240);
            check("frozen", 8'h00, {7'h00, sleep_req});
            host.set_scl(1'b1);
            host.tick(2);
            ce = 1'b1;
            host.tick(2);
            check("thawed", 8'h00, {7'h00, sleep_req});
        end
    endtask
    // Reset in mid-run returns the pointer to its reset value
    task sc_rerst;
        begin
            rst = 1'b1;
            host.tick(2);
            rst = 1'b0;
            check("ptr_rst2", 8'h00, cmd_ptr);
            host.tick(2);
        end
    endtask
    // Watchdog for a hung run
    initial begin
        repeat (100000) @(posedge clock);
        mismatches = mismatches + 1;
        conclude;
    end
    // Main sequence
    initial begin
        mismatches = 0;
        samples_checked = 0;
        rst = 1'b1;
        ce = 1'b1;
        sealed = 1'b0;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        check("ptr_rst", 8'h00, cmd_ptr);
        sc_write;
        sc_refuse;
        sc_read;
        sc_top;
        sc_rerst;
        sc_stuck;
        sc_freeze;
        conclude;
    end
endmodule
